// ---- logic/bsdm_core.sv ----
// Byte swap and digit copy datapath with Wishbone control registers
//
// Summary of operation
// - 16-bit swap exchanges low and high byte of the word, written back.
// - 32-bit swap swaps bytes within each word, words stay in place.
// - 32-bit counter operand is refused by the 16-bit swap.
// - Digit copy moves count digits from source start to destination start.
// - Digits 1..4 of four bits; start 1..4, count 1..start, dest count..4.
// - Mode flag clear: words are decimal values, digits moved decimally.
// - Mode flag set: raw nibbles moved, no decimal conversion.
// - Decimal mode value outside 0..9999 skips, flags error, code 200D.
// - Source start outside 1..4 skips, flags error, code 200B.
// - Count below 1 or above source start skips, flags error, code 200B.
// - Dest start below count or above 4 skips, flags error, code 200B.
//
// The implementer's own choices: the address map and the Wishbone slave port.
module bsdm_core (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   // Sequencer request
   input wire logic exec_in,
   input wire bsdm_pkg::bsdm_req_t req_in,
   // Result towards operand store
   output bsdm_pkg::bsdm_res_t res_out,
   output logic done_out,
   output logic err_flag_out,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [bsdm_pkg::ADR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out
);

   // ---------------------------------------------
   // Conversion helpers
   // ---------------------------------------------
   // Binary to packed decimal by shift and add three
   function automatic logic [15:0] bsdm_to_bcd(input logic [15:0] v);
      logic [31:0] s;
      s = {16'h0000, v};
      for (int i = 0; i < 16; i++) begin
         for (int d = 0; d < bsdm_pkg::DIGITS; d++) begin
            if (s[16 + 4*d +: 4] > 4'h4) begin
               s[16 + 4*d +: 4] = s[16 + 4*d +: 4] + 4'h3;
            end
         end
         s = s << 1;
      end
      return s[31:16];
   endfunction : bsdm_to_bcd

   // Packed decimal back to binary, most significant digit first
   function automatic logic [15:0] bsdm_from_bcd(input logic [15:0] b);
      logic [15:0] r;
      r = 16'h0000;
      for (int d = bsdm_pkg::DIGITS - 1; d >= 0; d--) begin
         r = 16'(r * bsdm_pkg::DEC_BASE + 16'(b[4*d +: 4]));
      end
      return r;
   endfunction : bsdm_from_bcd

   // ---------------------------------------------
   // Control registers
   // ---------------------------------------------
   logic digit_binary_mode_flag;
   logic operation_error_flag;
   logic [15:0] error_code_word;
   logic wb_req;
   logic wb_wr;
   logic err_clr;

   assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
   // Writes land at the edge where the master samples ack, not a cycle early
   assign wb_wr = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0];
   assign err_clr = wb_wr && (wb_adr_in == bsdm_pkg::REG_STAT)
                    && wb_dat_in[bsdm_pkg::STAT_ERR_BIT];

   // ---------------------------------------------
   // Operand checks
   // ---------------------------------------------
   logic is_copy;
   logic bad_cnt;
   logic bad_bcd;
   logic bad_start;
   logic bad_count;
   logic bad_n;
   logic bad_any;
   logic [15:0] err_sel;

   assign is_copy = req_in.op == bsdm_pkg::BSDM_DCOPY;
   // Only the 16-bit swap refuses a counter operand
   assign bad_cnt = req_in.op == bsdm_pkg::BSDM_SWAP16 && req_in.cnt32;
   // Range of the decimal values, unsigned so negatives fail too
   assign bad_bcd = is_copy && !digit_binary_mode_flag
                    && (req_in.src[15:0] > bsdm_pkg::DEC_MAX
                        || req_in.dst > bsdm_pkg::DEC_MAX);
   assign bad_start = is_copy && (req_in.source_start_digit < bsdm_pkg::DIG_MIN
                                  || req_in.source_start_digit > bsdm_pkg::DIG_MAX);
   assign bad_count = is_copy && (req_in.digit_count < bsdm_pkg::DIG_MIN
                                  || req_in.digit_count > req_in.source_start_digit);
   assign bad_n = is_copy && (req_in.n < req_in.digit_count
                              || req_in.n > bsdm_pkg::DIG_MAX);
   assign bad_any = bad_cnt || bad_bcd || bad_start || bad_count || bad_n;

   // Decimal range error reported ahead of the digit range codes
   always_comb begin
      if (bad_bcd) begin
         err_sel = bsdm_pkg::ERR_BCD;
      end else if (bad_cnt) begin
         err_sel = bsdm_pkg::ERR_CNT;
      end else begin
         err_sel = bsdm_pkg::ERR_RANGE;
      end
   end

   // ---------------------------------------------
   // Digit copy datapath
   // ---------------------------------------------
   logic [15:0] src_dig;
   logic [15:0] dst_dig;
   logic [15:0] cpy_dig;
   logic [15:0] cpy_word;
   logic [2:0] start_s;
   logic [2:0] cnt_s;
   logic [2:0] n_s;

   // Decimal mode works on the decimal digits of the values
   assign src_dig = digit_binary_mode_flag ? req_in.src[15:0]
                    : bsdm_to_bcd(req_in.src[15:0]);
   assign dst_dig = digit_binary_mode_flag ? req_in.dst
                    : bsdm_to_bcd(req_in.dst);
   // Small copies; only meaningful once the range checks pass
   assign start_s = req_in.source_start_digit[2:0];
   assign cnt_s = req_in.digit_count[2:0];
   assign n_s = req_in.n[2:0];

   // Destination digit p+1 takes source digit m1-n+p+1 when in the window
   for (genvar p = 0; p < bsdm_pkg::DIGITS; p++) begin : g_dig
      logic take;
      logic [2:0] si;
      // Difference form: a sum of position and count would wrap at digit 4
      assign take = (3'(p + 1) <= n_s) && (3'(p + 1) > n_s - cnt_s);
      assign si = 3'(start_s - n_s + 3'(p));
      assign cpy_dig[p*bsdm_pkg::NIB_W +: bsdm_pkg::NIB_W] = take
         ? src_dig[si[1:0]*bsdm_pkg::NIB_W +: bsdm_pkg::NIB_W]
         : dst_dig[p*bsdm_pkg::NIB_W +: bsdm_pkg::NIB_W];
   end

   // Back to a binary value in decimal mode
   assign cpy_word = digit_binary_mode_flag ? cpy_dig
                     : bsdm_from_bcd(cpy_dig);

   // ---------------------------------------------
   // Result and done
   // ---------------------------------------------
   logic [31:0] next_data;

   always_comb begin
      case (req_in.op)
         bsdm_pkg::BSDM_SWAP16: begin
            next_data = {req_in.src[31:16], req_in.src[7:0], req_in.src[15:8]};
         end
         bsdm_pkg::BSDM_SWAP32: begin
            // Words keep their places, only the bytes inside turn
            next_data = {req_in.src[23:16], req_in.src[31:24],
                         req_in.src[7:0], req_in.src[15:8]};
         end
         bsdm_pkg::BSDM_DCOPY: begin
            // Upper half cleared to zero; the store takes all 32 bits of the result
            next_data = {16'h0000, cpy_word};
         end
         default: begin
            next_data = 32'h0000_0000;
         end
      endcase
   end

   // Write-back only for accepted operations, done for every one
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         res_out <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= exec_in;
         res_out.wr <= exec_in && !bad_any;
         if (exec_in && !bad_any) begin
            res_out.data <= next_data;
         end
      end
   end

   // Error flag: a new error wins over a software clear in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         operation_error_flag <= 1'b0;
      end else if (exec_in && bad_any) begin
         operation_error_flag <= 1'b1;
      end else if (err_clr) begin
         operation_error_flag <= 1'b0;
      end
   end

   // Code keeps the last error until the next one
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         error_code_word <= bsdm_pkg::CODE_RST;
      end else if (exec_in && bad_any) begin
         error_code_word <= err_sel;
      end
   end

   assign err_flag_out = operation_error_flag;

   // ---------------------------------------------
   // Wishbone slave
   // ---------------------------------------------
   // Mode flag written by software
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         digit_binary_mode_flag <= 1'b0;
      end else if (wb_wr && wb_adr_in == bsdm_pkg::REG_CTRL) begin
         digit_binary_mode_flag <= wb_dat_in[bsdm_pkg::CTRL_BIN_BIT];
      end
   end

   // One wait state: ack and read data one edge after the request
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= wb_req;
         wb_dat_out <= 32'h0000_0000;
         if (wb_req && !wb_we_in) begin
            case (wb_adr_in)
               bsdm_pkg::REG_CTRL: begin
                  wb_dat_out[bsdm_pkg::CTRL_BIN_BIT] <= digit_binary_mode_flag;
               end
               bsdm_pkg::REG_STAT: begin
                  wb_dat_out[bsdm_pkg::STAT_ERR_BIT] <= operation_error_flag;
               end
               bsdm_pkg::REG_CODE: begin
                  wb_dat_out[15:0] <= error_code_word;
               end
               default: begin
                  wb_dat_out <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);

   done_one_cycle_a: assert property (
      done_out == $past(exec_in))
      else $error("done not one cycle after execute");

   swap_word_a: assert property (
      exec_in && req_in.op == bsdm_pkg::BSDM_SWAP16 && !req_in.cnt32
      |=> res_out.wr && res_out.data[15:0] == {$past(req_in.src[7:0]), $past(req_in.src[15:8])})
      else $error("16-bit swap result wrong");

   swap_dword_a: assert property (
      exec_in && req_in.op == bsdm_pkg::BSDM_SWAP32
      |=> res_out.wr && res_out.data[31:16] == {$past(req_in.src[23:16]), $past(req_in.src[31:24])})
      else $error("32-bit swap crossed words");

   counter_refused_a: assert property (
      exec_in && req_in.op == bsdm_pkg::BSDM_SWAP16 && req_in.cnt32
      |=> !res_out.wr && operation_error_flag)
      else $error("counter operand accepted by 16-bit swap");

   bcd_range_a: assert property (
      exec_in && bad_bcd |=> !res_out.wr && error_code_word == bsdm_pkg::ERR_BCD)
      else $error("decimal range error not reported");

   start_range_a: assert property (
      exec_in && is_copy && !bad_bcd && (req_in.source_start_digit < bsdm_pkg::DIG_MIN
                                         || req_in.source_start_digit > bsdm_pkg::DIG_MAX)
      |=> !res_out.wr && operation_error_flag && error_code_word == bsdm_pkg::ERR_RANGE)
      else $error("bad source start accepted");

   count_range_a: assert property (
      exec_in && is_copy && req_in.digit_count > req_in.source_start_digit
      |=> !res_out.wr && operation_error_flag)
      else $error("bad digit count accepted");

   dest_range_a: assert property (
      exec_in && is_copy && req_in.n < req_in.digit_count |=> !res_out.wr && operation_error_flag)
      else $error("bad destination start accepted");

   raw_nibbles_a: assert property (
      exec_in && is_copy && digit_binary_mode_flag && req_in.source_start_digit == bsdm_pkg::DIG_MAX
      && req_in.digit_count == bsdm_pkg::DIG_MIN && req_in.n == bsdm_pkg::DIG_MAX
      |=> res_out.data[15:0] == {$past(req_in.src[15:12]), $past(req_in.dst[11:0])})
      else $error("binary digit copy wrong");

   decimal_copy_a: assert property (
      exec_in && is_copy && !bad_any && !digit_binary_mode_flag && req_in.digit_count == bsdm_pkg::DIG_MAX
      |=> res_out.wr && res_out.data[15:0] == $past(req_in.src[15:0]))
      else $error("decimal full copy wrong");

   write_with_done_a: assert property (
      res_out.wr |-> done_out)
      else $error("write-back without done");

   error_sets_flag_a: assert property (
      exec_in && bad_any |=> operation_error_flag && !res_out.wr)
      else $error("refused operation left flag clear");

   swap_upper_kept_a: assert property (
      exec_in && req_in.op == bsdm_pkg::BSDM_SWAP16 && !req_in.cnt32
      |=> res_out.data[31:16] == $past(req_in.src[31:16]))
      else $error("16-bit swap disturbed the upper word");

   swap_low_word_a: assert property (
      exec_in && req_in.op == bsdm_pkg::BSDM_SWAP32
      |=> res_out.data[15:0] == {$past(req_in.src[7:0]), $past(req_in.src[15:8])})
      else $error("32-bit swap lower word wrong");

   count_code_a: assert property (
      exec_in && is_copy && !bad_bcd && req_in.digit_count < bsdm_pkg::DIG_MIN
      |=> error_code_word == bsdm_pkg::ERR_RANGE)
      else $error("zero digit count code wrong");

   dest_code_a: assert property (
      exec_in && is_copy && !bad_bcd && req_in.n > bsdm_pkg::DIG_MAX
      |=> !res_out.wr && error_code_word == bsdm_pkg::ERR_RANGE)
      else $error("destination start above four accepted");

   low_nibble_a: assert property (
      exec_in && is_copy && digit_binary_mode_flag && req_in.source_start_digit == bsdm_pkg::DIG_MIN
      && req_in.digit_count == bsdm_pkg::DIG_MIN && req_in.n == bsdm_pkg::DIG_MIN
      |=> res_out.data[15:0] == {$past(req_in.dst[15:4]), $past(req_in.src[3:0])})
      else $error("single low digit copy wrong");

endmodule : bsdm_core

// ---- shared/bsdm_pkg.sv ----
// Constants and carrier types for the byte swap and digit copy datapath
package bsdm_pkg;

   // ---------------------------------------------
   // Operations and carriers
   // ---------------------------------------------
   typedef enum logic [1:0] {
      BSDM_SWAP16,
      BSDM_SWAP32,
      BSDM_DCOPY
   } bsdm_op_t;

   // Request from the sequencer, taken with the execute strobe
   typedef struct packed {
      bsdm_op_t op;
      logic cnt32;
      logic [31:0] src;
      logic [15:0] dst;
      logic [15:0] source_start_digit;
      logic [15:0] digit_count;
      logic [15:0] n;
   } bsdm_req_t;

   // Write-back towards the operand store
   typedef struct packed {
      logic wr;
      logic [31:0] data;
   } bsdm_res_t;

   // ---------------------------------------------
   // Digits and error codes
   // ---------------------------------------------
   localparam int NIB_W = 4;
   localparam int DIGITS = 4;
   localparam logic [15:0] DIG_MIN = 16'h0001;
   localparam logic [15:0] DIG_MAX = 16'h0004;
   localparam logic [15:0] DEC_MAX = 16'h270F;
   localparam logic [15:0] DEC_BASE = 16'h000A;
   localparam logic [15:0] ERR_BCD = 16'h200D;
   localparam logic [15:0] ERR_RANGE = 16'h200B;
   localparam logic [15:0] ERR_CNT = 16'h200B;

   // ---------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------
   localparam int ADR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_CODE = 4'h8;
   localparam int CTRL_BIN_BIT = 0;
   localparam int STAT_ERR_BIT = 0;
   localparam logic [15:0] CODE_RST = 16'h0000;

endpackage : bsdm_pkg

// ---- testbench/bsdm_store.sv ----
// Operand store model: keeps the last word written back by the datapath
module bsdm_store (
   // Clock
   input wire logic ref_clk_in,
   // Write-back from the datapath
   input wire bsdm_pkg::bsdm_res_t res_in,
   // Stored word and write count
   output logic [31:0] word_out,
   output logic [15:0] n_wr_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial word_out = 32'h0000_0000;
   initial n_wr_out = 16'h0000;
   // Take a word only on the write pulse, so a refused op leaves the store alone
   always @(posedge ref_clk_in) begin
      if (res_in.wr === 1'b1) begin
         word_out <= res_in.data;
         n_wr_out <= n_wr_out + 16'h0001;
      end
   end
endmodule : bsdm_store

// ---- testbench/bsdm_core_bench.sv ----
// Self-checking bench for the byte swap and digit copy datapath
module bsdm_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic wr; logic [31:0] data; logic err; logic [15:0] code;} bsdm_note_t;
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic exec_in = 1'b0;
   bsdm_pkg::bsdm_req_t req_in = '0;
   bsdm_pkg::bsdm_res_t res_out;
   logic done_out, err_flag_out, wb_ack_out, bin = 1'b0, any_err = 1'b0;
   logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic [3:0] wb_adr_in = 4'h0, wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0000_0000, wb_dat_out, word, rd, lfsr = 32'h3732_f8d3;
   logic [15:0] n_wr, last_code = 16'h0000;
   int errors = 0, n_tests = 0, n_exp_wr = 0;
   bsdm_note_t notes[$];
   bsdm_note_t nt;

   // -------------------------------------------
   // Clock, design and store model
   // -------------------------------------------
   always #25 ref_clk_in = ~ref_clk_in;
   bsdm_core DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .exec_in(exec_in), .req_in(req_in),
      .res_out(res_out), .done_out(done_out), .err_flag_out(err_flag_out), .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
      .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
   bsdm_store store (.ref_clk_in(ref_clk_in), .res_in(res_out), .word_out(word), .n_wr_out(n_wr));

   // -------------------------------------------
   // Helpers
   // -------------------------------------------
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   // Reference result; decimal digits are worked out arithmetically, not by nibble
   function automatic bsdm_note_t expect_of(bsdm_pkg::bsdm_req_t r, logic b);
      bsdm_note_t e;
      int s[5];
      int d[5];
      int v;
      e = '{1'b1, 32'h0000_0000, 1'b0, 16'h0000};
      if (r.op == bsdm_pkg::BSDM_SWAP16) begin
         e.data = {r.src[31:16], r.src[7:0], r.src[15:8]};
         if (r.cnt32) e.code = 16'h200B;
      end else if (r.op == bsdm_pkg::BSDM_SWAP32) begin
         e.data = {r.src[23:16], r.src[31:24], r.src[7:0], r.src[15:8]};
      end else if (!b && (r.src[15:0] > 16'h270F || r.dst > 16'h270F)) begin
         e.code = 16'h200D;
      end else if (r.source_start_digit < 16'h0001 || r.source_start_digit > 16'h0004
                   || r.digit_count < 16'h0001 || r.digit_count > r.source_start_digit
                   || r.n < r.digit_count || r.n > 16'h0004) begin
         e.code = 16'h200B;
      end else begin
         for (int k = 1; k <= 4; k++) begin
            s[k] = b ? int'(r.src[4*k-4 +: 4]) : (int'(r.src[15:0]) / 10**(k-1)) % 10;
            d[k] = b ? int'(r.dst[4*k-4 +: 4]) : (int'(r.dst) / 10**(k-1)) % 10;
         end
         for (int k = 0; k < int'(r.digit_count); k++) d[int'(r.n)-k] = s[int'(r.source_start_digit)-k];
         v = 0;
         for (int k = 4; k >= 1; k--) v = b ? v * 16 + d[k] : v * 10 + d[k];
         e.data = {16'h0000, v[15:0]};
      end
      e.err = (e.code != 16'h0000);
      e.wr = !e.err;
      return e;
   endfunction : expect_of

   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   // Classic single Wishbone cycle; the request is held until ack is seen
   task automatic wb(logic we, logic [3:0] adr, logic [31:0] dat);
      @(posedge ref_clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= adr;
      wb_dat_in <= dat;
      wb_sel_in <= 4'hF;
      for (int i = 0; i < 20; i++) begin
         @(posedge ref_clk_in);
         if (wb_ack_out === 1'b1) break;
         if (i == 19) begin
            check("ack", 32'h1, 32'h0);
            test_done();
         end
      end
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask : wb

   // Operands and strobe leave together; the expected result is queued for the monitor
   task automatic send(bsdm_pkg::bsdm_op_t op, logic c, logic [31:0] s, logic [15:0] d,
                       logic [15:0] start, logic [15:0] cnt, logic [15:0] n);
      bsdm_pkg::bsdm_req_t r;
      bsdm_note_t e;
      r = '{op, c, s, d, start, cnt, n};
      @(posedge ref_clk_in);
      exec_in <= 1'b1;
      req_in <= r;
      // Own note variable: the monitor uses nt in the same time step
      e = expect_of(r, bin);
      notes.push_back(e);
      if (e.err) last_code = e.code;
      any_err |= e.err;
      n_exp_wr += int'(e.wr);
   endtask : send

   task automatic idle();
      @(posedge ref_clk_in);
      exec_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
   endtask : idle

   // Monitor: done marks a result, matched against the oldest note
   always @(posedge ref_clk_in) begin
      if (done_out === 1'b1) begin
         if (notes.size() == 0) check("note", 32'h1, 32'h0);
         else begin
            nt = notes.pop_front();
            check("wr", {31'h0, nt.wr}, {31'h0, res_out.wr});
            if (nt.wr) check("data", nt.data, res_out.data);
            if (nt.err) check("err", 32'h1, {31'h0, err_flag_out});
         end
      end
   end

   // -------------------------------------------
   // Main sequence
   // -------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      wb(1'b0, bsdm_pkg::REG_CODE, 32'h0);
      check("code_rst", 32'h0, rd);
      send(bsdm_pkg::BSDM_DCOPY, 1'b0, 32'h0000_04D2, 16'h162E, 16'h4, 16'h4, 16'h4);
      send(bsdm_pkg::BSDM_DCOPY, 1'b0, 32'h0000_04D2, 16'h162E, 16'h4, 16'h2, 16'h3);
      idle();
      check("dec_word", 32'h0000_1408, word);
      wb(1'b1, bsdm_pkg::REG_CTRL, 32'h1);
      bin = 1'b1;
      wb(1'b0, bsdm_pkg::REG_CTRL, 32'h0);
      check("ctrl", 32'h1, rd);
      send(bsdm_pkg::BSDM_DCOPY, 1'b0, 32'h0000_1234, 16'h5678, 16'h4, 16'h2, 16'h3);
      send(bsdm_pkg::BSDM_DCOPY, 1'b0, 32'h0000_1234, 16'h5678, 16'h4, 16'h1, 16'h4);
      send(bsdm_pkg::BSDM_DCOPY, 1'b0, 32'h0000_1234, 16'h5678, 16'h1, 16'h1, 16'h1);
      send(bsdm_pkg::BSDM_SWAP16, 1'b1, 32'hA1B2_C3D4, 16'h0, 16'h0, 16'h0, 16'h0);
      send(bsdm_pkg::BSDM_SWAP32, 1'b1, 32'hA1B2_C3D4, 16'h0, 16'h0, 16'h0, 16'h0);
      idle();
      check("bin_word", 32'hB2A1_D4C3, word);
      wb(1'b0, 4'hC, 32'h0);
      check("unmapped", 32'h0, rd);
      // The refused counter swap left the flag up; clear it before the bursts
      wb(1'b0, bsdm_pkg::REG_STAT, 32'h0);
      check("stat_dir", 32'h1, rd);
      wb(1'b1, bsdm_pkg::REG_STAT, 32'h1);
      $display("directed test done");
      // Random bursts, back to back, mode flipped each burst
      for (int b = 0; b < 40; b++) begin
         bin = b[0];
         any_err = 1'b0;
         wb(1'b1, bsdm_pkg::REG_CTRL, {31'h0, bin});
         check("cleared", 32'h0, {31'h0, err_flag_out});
         repeat (4) send(bsdm_pkg::bsdm_op_t'(2'(rnd() % 3)), 1'(rnd()), bin ? rnd() : rnd() % 12000,
            bin ? 16'(rnd()) : 16'(rnd() % 12000), 16'(rnd() % 6), 16'(rnd() % 6), 16'(rnd() % 6));
         idle();
         wb(1'b0, bsdm_pkg::REG_CODE, 32'h0);
         check("code", {16'h0, last_code}, rd);
         wb(1'b0, bsdm_pkg::REG_STAT, 32'h0);
         check("status", {31'h0, any_err}, rd);
         wb(1'b1, bsdm_pkg::REG_STAT, 32'h1);
      end
      repeat (3) @(posedge ref_clk_in);
      check("pending", 32'h0, notes.size());
      check("writes", n_exp_wr, {16'h0, n_wr});
      $display("random test done");
      test_done();
   end
endmodule : bsdm_core_bench
